// ==== rtl/gpxbi_core.sv ====
// port core: input sampling, change detect, two-phase outputs, pin filters
//
// How it works
// - sixteen open-drain port pins, each input or output, set through registers
// - after reset all ports are inputs and no pin is pulled low
// - reset returns every piece of state to its power-up value except port_pins_out and irq_or_extra_output_out, which load low every clock
// - address-select pin decoded as ground, supply, clock line or data line
// - clock and data spikes shorter than 50 ns are filtered away
// - extra pin works as active-low interrupt or as general output
// - as general output the extra pin uses the same phase and blink controls
// - input registers return the real pin level, input or output
// - reading an input register snapshots that register's eight pins
// - only input-configured ports are compared against the snapshot each cycle
// - any mismatch pulls the interrupt low while interrupt mode is chosen
// - interrupt releases once all changed inputs return to snapshot level
// - reading the covering input register clears the interrupt by resnapshot
// - phase-0 registers set all sixteen outputs when blink is off
// - with blink on, outputs swap phases by blink pin xor flip flag
// - blink pin level readable as status bit in the configuration register
// - blink pin sampled always, so it serves as general input
// - seven-bit slave address, bits six and two from address-select pin
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps
module gpxbi_core
  import gpxbi_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic [15:0] port_pins_in,
  output logic      [15:0] port_pins_out,
  output logic      [15:0] port_pins_oe,
  output logic             irq_or_extra_output_out,
  output logic             irq_or_extra_output_oe,
  input  wire logic        blink_in,
  input  wire logic        addr_select_pin,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             scl_filt,
  output logic             sda_filt,
  output logic      [6:0]  slave_addr
);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [19:0] sync1;
  logic [19:0] sync2;
  logic [15:0] pins;
  logic        scl_s;
  logic        sda_s;
  logic        blink_s;
  logic        ad_s;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sync1 <= '1;  // lines idle high; zeros here would fake a low on the bus lines
      sync2 <= '1;
    end
    else
    begin
      sync1 <= {addr_select_pin, blink_in, sda_in, scl_in, port_pins_in};
      sync2 <= sync1;
    end
  end

  assign pins    = sync2[15:0];
  assign scl_s   = sync2[16];
  assign sda_s   = sync2[17];
  assign blink_s = sync2[18];
  assign ad_s    = sync2[19];

  // ----------------------------------------
  // spike filters
  // ----------------------------------------
  logic [1:0] filt;
  logic [1:0] line_s;

  assign line_s = {sda_s, scl_s};

  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_filt
      logic [2:0] cnt;
      logic [2:0] next_cnt;
      logic       next_filt;

      always_comb
      begin
        next_cnt  = 3'h0;
        next_filt = filt[i];
        // a level must hold the full spike window before it is believed
        if (line_s[i] != filt[i])
        begin
          if (cnt == SPIKE_LAST)
            next_filt = line_s[i];
          else
            next_cnt = cnt + 3'h1;
        end
      end

      always_ff @(posedge clk_sys)
      begin
        if (rst)
        begin
          cnt     <= 3'h0;
          filt[i] <= 1'b1;
        end
        else
        begin
          cnt     <= next_cnt;
          filt[i] <= next_filt;
        end
      end
    end
  endgenerate

  assign scl_filt = filt[0];
  assign sda_filt = filt[1];

  // ----------------------------------------
  // address-select decode
  // ----------------------------------------
  gpxbi_ad_t  ad;
  gpxbi_ad_t  next_ad;
  gpxbi_ads_t ads;
  logic [6:0] next_slave_addr;

  always_comb
  begin
    next_ad              = ad;
    next_ad.diff_scl     = ad.diff_scl | (ad_s != scl_s);
    next_ad.diff_sda     = ad.diff_sda | (ad_s != sda_s);
    next_ad.seen_scl_low = ad.seen_scl_low | ~scl_s;
    next_ad.seen_sda_low = ad.seen_sda_low | ~sda_s;
    // a pin strapped to a bus line looks like supply until that line moves
    if (!ad.diff_scl && ad.seen_scl_low)
      ads = ADS_SCL;
    else if (!ad.diff_sda && ad.seen_sda_low)
      ads = ADS_SDA;
    else if (ad_s)
      ads = ADS_VCC;
    else
      ads = ADS_GND;
    next_slave_addr = SLAVE_FIXED;
    next_slave_addr[SA_HI_BIT] = (ads == ADS_SCL) || (ads == ADS_SDA);
    next_slave_addr[SA_LO_BIT] = (ads == ADS_VCC) || (ads == ADS_SDA);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ad         <= AD_RST;
      slave_addr <= SLAVE_FIXED;
    end
    else
    begin
      ad         <= next_ad;
      slave_addr <= next_slave_addr;
    end
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [15:0] phase0;
  logic [15:0] phase1;
  logic [15:0] dir_in;
  logic [15:0] snap;
  gpxbi_cfg_t  cfg;
  logic [15:0] next_phase0;
  logic [15:0] next_phase1;
  logic [15:0] next_dir_in;
  logic [15:0] next_snap;
  gpxbi_cfg_t  next_cfg;
  logic [7:0]  next_rdata;

  function automatic logic [15:0] wr_pair(input logic [15:0] cur, input logic [7:0] base);
    logic [15:0] res;
    res = cur;
    if (reg_wr && reg_addr == base)
      res[7:0] = reg_wdata;
    if (reg_wr && reg_addr == base + 8'h01)
      res[15:8] = reg_wdata;
    return res;
  endfunction

  always_comb
  begin
    next_phase0 = wr_pair(phase0, ADDR_P0_LO);
    next_phase1 = wr_pair(phase1, ADDR_P1_LO);
    next_dir_in = wr_pair(dir_in, ADDR_DIR_LO);
    next_cfg    = cfg;
    if (reg_wr && reg_addr == ADDR_CFG)
      next_cfg = reg_wdata[4:0];
    next_snap = snap;
    if (reg_rd && reg_addr == ADDR_IN_LO)
      next_snap[7:0] = pins[7:0];
    if (reg_rd && reg_addr == ADDR_IN_HI)
      next_snap[15:8] = pins[15:8];
    next_rdata = RDATA_RST;
    if (reg_rd)
    begin
      unique case (reg_addr)
        ADDR_IN_LO:  next_rdata = pins[7:0];
        ADDR_IN_HI:  next_rdata = pins[15:8];
        ADDR_P0_LO:  next_rdata = phase0[7:0];
        ADDR_P0_HI:  next_rdata = phase0[15:8];
        ADDR_P1_LO:  next_rdata = phase1[7:0];
        ADDR_P1_HI:  next_rdata = phase1[15:8];
        ADDR_DIR_LO: next_rdata = dir_in[7:0];
        ADDR_DIR_HI: next_rdata = dir_in[15:8];
        ADDR_CFG:
        begin
          next_rdata                 = {3'h0, cfg};
          next_rdata[CFG_STATUS_BIT] = blink_s;
        end
        default:     next_rdata = RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      phase0    <= PHASE_RST;
      phase1    <= PHASE_RST;
      dir_in    <= DIR_RST;
      snap      <= SNAP_RST;
      cfg       <= CFG_RST;
      reg_rdata <= RDATA_RST;
    end
    else
    begin
      phase0    <= next_phase0;
      phase1    <= next_phase1;
      dir_in    <= next_dir_in;
      snap      <= next_snap;
      cfg       <= next_cfg;
      reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // output drive and change detect
  // ----------------------------------------
  logic        sel_p1;
  logic [15:0] outv;
  logic        o16v;
  logic [15:0] mismatch;
  logic [15:0] next_port_oe;
  logic        next_irq_oe;

  always_comb
  begin
    sel_p1       = cfg.blink_en & (blink_s ^ cfg.flip);
    outv         = sel_p1 ? phase1 : phase0;
    o16v         = sel_p1 ? cfg.o16_p1 : cfg.o16_p0;
    next_port_oe = ~dir_in & ~outv;
    // pins driven by us never count as a change
    mismatch     = (pins ^ snap) & dir_in;
    if (cfg.irq_en)
      next_irq_oe = |mismatch;
    else
      next_irq_oe = ~o16v;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      port_pins_oe           <= '0;
      irq_or_extra_output_oe <= 1'b0;
    end
    else
    begin
      port_pins_oe           <= next_port_oe;
      irq_or_extra_output_oe <= next_irq_oe;
    end
  end

  // open drain: the level is always low, only the enable moves
  always_ff @(posedge clk_sys)
  begin
    port_pins_out           <= '0;
    irq_or_extra_output_out <= 1'b0;
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence rd_in_lo_s;
    reg_rd && reg_addr == ADDR_IN_LO;
  endsequence

  sequence rd_cfg_s;
    reg_rd && reg_addr == ADDR_CFG;
  endsequence

  AST_RESET_RELEASE: assert property (@(posedge clk_sys) $fell(rst) |-> port_pins_oe == 16'h0000 && !irq_or_extra_output_oe)
    else $error("pins driven right after reset");
  AST_READ_LEVEL: assert property (rd_in_lo_s |=> reg_rdata == $past(pins[7:0]))
    else $error("input read does not show pin level");
  AST_SNAPSHOT: assert property (rd_in_lo_s |=> snap[7:0] == $past(pins[7:0]))
    else $error("input read did not snapshot");
  AST_IRQ_SET: assert property (cfg.irq_en && |((pins ^ snap) & dir_in) |=> irq_or_extra_output_oe)
    else $error("change on input did not raise interrupt");
  AST_IRQ_CLEAR: assert property (cfg.irq_en && ((pins ^ snap) & dir_in) == 16'h0000 |=> !irq_or_extra_output_oe)
    else $error("interrupt held with no change");
  AST_EXTRA_OUT: assert property (!cfg.irq_en && !cfg.blink_en |=> irq_or_extra_output_oe == !$past(cfg.o16_p0))
    else $error("extra output level wrong");
  AST_STATIC_OUT: assert property (!cfg.blink_en |=> port_pins_oe == $past(~dir_in & ~phase0))
    else $error("static outputs wrong");
  AST_BLINK_OUT: assert property (cfg.blink_en && (blink_s ^ cfg.flip) |=> port_pins_oe == $past(~dir_in & ~phase1))
    else $error("blink phase one not selected");
  AST_STATUS_BIT: assert property (rd_cfg_s |=> reg_rdata[CFG_STATUS_BIT] == $past(blink_s))
    else $error("blink status bit wrong");
  AST_SPIKE: assert property ($changed(scl_filt) |-> $past(scl_s, 1) == scl_filt && $past(scl_s, 5) == scl_filt)
    else $error("clock filter passed a short spike");
  AST_SLAVE_FIXED: assert property (slave_addr[5] && !slave_addr[4] && !slave_addr[3] && slave_addr[1:0] == 2'h0)
    else $error("fixed slave address bits wrong");
  AST_AD_GND: assert property (ads == ADS_GND |=> !slave_addr[SA_HI_BIT] && !slave_addr[SA_LO_BIT])
    else $error("ground strap gives wrong address");

endmodule

// ==== rtl/gpxbi_pkg.sv ====
// constants and types for the gpio expander port core
package gpxbi_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int       CLK_PERIOD_NS = 10;
  localparam int       SPIKE_NS      = 50;
  localparam int       SPIKE_CYC     = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] SPIKE_LAST  = 3'(SPIKE_CYC - 1);

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_IN_LO  = 8'h00;
  localparam logic [7:0] ADDR_IN_HI  = 8'h01;
  localparam logic [7:0] ADDR_P0_LO  = 8'h02;
  localparam logic [7:0] ADDR_P0_HI  = 8'h03;
  localparam logic [7:0] ADDR_P1_LO  = 8'h04;
  localparam logic [7:0] ADDR_P1_HI  = 8'h05;
  localparam logic [7:0] ADDR_DIR_LO = 8'h06;
  localparam logic [7:0] ADDR_DIR_HI = 8'h07;
  localparam logic [7:0] ADDR_CFG    = 8'h0f;

  // ----------------------------------------
  // reset values and field positions
  // ----------------------------------------
  localparam logic [15:0] PHASE_RST  = 16'hffff;
  localparam logic [15:0] DIR_RST    = 16'hffff;
  localparam logic [15:0] SNAP_RST   = 16'h0000;
  localparam logic [7:0]  RDATA_RST  = 8'h00;
  localparam int          CFG_STATUS_BIT = 7;
  localparam logic [6:0]  SLAVE_FIXED    = 7'h20;
  localparam int          SA_HI_BIT      = 6;
  localparam int          SA_LO_BIT      = 2;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic irq_en;
    logic o16_p1;
    logic o16_p0;
    logic flip;
    logic blink_en;
  } gpxbi_cfg_t;

  localparam gpxbi_cfg_t CFG_RST = '{irq_en: 1'b0, o16_p1: 1'b1, o16_p0: 1'b1, flip: 1'b0, blink_en: 1'b0};

  typedef struct packed {
    logic seen_scl_low;
    logic seen_sda_low;
    logic diff_scl;
    logic diff_sda;
  } gpxbi_ad_t;

  localparam gpxbi_ad_t AD_RST = '{default: 1'b0};

  typedef enum logic [1:0] {ADS_GND, ADS_VCC, ADS_SCL, ADS_SDA} gpxbi_ads_t;

endpackage

// ==== testbench/gpxbi_pin_env.sv ====
// pin and bus-line environment around the port core
`timescale 1ns/1ps
module gpxbi_pin_env (
  input  wire logic [15:0] port_pins_oe,
  input  wire logic [15:0] ext_low,
  input  wire logic        frame,
  input  wire logic        scl_low,
  input  wire logic        sda_low,
  input  wire logic [1:0]  strap_mode,
  output logic      [15:0] port_pins_in,
  output logic             scl_in,
  output logic             sda_in,
  output logic             addr_select_pin
);
  logic link_clk = 1'b0;
  logic sda_pat  = 1'b1;

  // link clock free in phase to clk_sys, seen on the line only within frames
  initial #13 forever #40 link_clk = ~link_clk;

  always @(negedge link_clk)
    sda_pat <= frame ? ~sda_pat : 1'b1;

  // ----------------------------------------
  // line resolution
  // ----------------------------------------
  always_comb
  begin
    port_pins_in = ~(port_pins_oe | ext_low); // pull-ups; any sinker wins
    scl_in       = ~scl_low & (frame ? link_clk : 1'b1);
    sda_in       = ~sda_low & (frame ? sda_pat : 1'b1);
    case (strap_mode)
      2'h0:    addr_select_pin = 1'b0;
      2'h1:    addr_select_pin = 1'b1;
      2'h2:    addr_select_pin = scl_in;
      default: addr_select_pin = sda_in;
    endcase
  end
endmodule

// ==== testbench/gpxbi_test.sv ====
// self-checking bench for the gpio expander port core
`timescale 1ns/1ps
module gpio_expander_blink_irq_test;
  import gpxbi_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic [15:0] port_pins_in, port_pins_out, port_pins_oe;
  logic        irq_or_extra_output_out, irq_or_extra_output_oe;
  logic        blink_in = 1'b0;
  logic        addr_select_pin, scl_in, sda_in, scl_filt, sda_filt;
  logic [6:0]  slave_addr;
  logic [15:0] ext_low = 16'h0000;
  logic        frame = 1'b0;
  logic        scl_low = 1'b0;
  logic        sda_low = 1'b0;
  logic [1:0]  strap_mode = 2'h0;
  int          n_mismatch = 0;
  int          compares = 0;
  int          cycles = 0;

  always #5 clk_sys = ~clk_sys;

  gpxbi_core DUT (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_pins_in(port_pins_in),
    .port_pins_out(port_pins_out), .port_pins_oe(port_pins_oe),
    .irq_or_extra_output_out(irq_or_extra_output_out), .irq_or_extra_output_oe(irq_or_extra_output_oe),
    .blink_in(blink_in), .addr_select_pin(addr_select_pin), .scl_in(scl_in), .sda_in(sda_in),
    .scl_filt(scl_filt), .sda_filt(sda_filt), .slave_addr(slave_addr));

  gpxbi_pin_env env (.port_pins_oe(port_pins_oe), .ext_low(ext_low), .frame(frame), .scl_low(scl_low),
    .sda_low(sda_low), .strap_mode(strap_mode), .port_pins_in(port_pins_in), .scl_in(scl_in),
    .sda_in(sda_in), .addr_select_pin(addr_select_pin));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic finish_test;
    if (n_mismatch == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_irq(input string what, input logic exp);
    chk(what, {15'h0000, exp}, {15'h0000, irq_or_extra_output_oe});
  endtask

  // sample point one ns past the edge so that edge's updates have landed
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic do_reset(input logic [1:0] mode);
    @(posedge clk_sys);
    rst        <= 1'b1;
    strap_mode <= mode;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    settle(8);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset(input logic [6:0] sa);
    logic [7:0] d;
    chk("pins_oe", 16'h0000, port_pins_oe);
    chk("pins_out", 16'h0000, port_pins_out);
    chk("extra_out", 16'h0000, {15'h0000, irq_or_extra_output_out});
    chk_irq("irq_oe", 1'b0);
    chk("slave_addr", {9'h000, sa}, {9'h000, slave_addr});
    rd(ADDR_DIR_LO, d);
    chk("dir_lo", 16'h00ff, {8'h00, d});
    rd(ADDR_CFG, d);
    chk("cfg", 16'h000c, {8'h00, d});
    rd(8'h10, d);
    chk("unmapped", 16'h0000, {8'h00, d});
  endtask

  task automatic t_inputs;
    logic [7:0] d;
    @(posedge clk_sys);
    ext_low <= 16'h5a3c;
    settle(4);
    rd(ADDR_IN_LO, d);
    chk("in_lo", 16'h00c3, {8'h00, d});
    rd(ADDR_IN_HI, d);
    chk("in_hi", 16'h00a5, {8'h00, d});
    settle(1);
    chk("rdata_idle", 16'h0000, {8'h00, reg_rdata});
    @(posedge clk_sys);
    ext_low <= 16'h0000;
    wr(ADDR_P0_LO, 8'hfe);
    wr(ADDR_DIR_LO, 8'hfe);
    settle(4);
    chk("oe_out", 16'h0001, port_pins_oe);
    rd(ADDR_IN_LO, d);
    chk("in_driven", 16'h00fe, {8'h00, d});
  endtask

  task automatic t_irq;
    logic [7:0] d;
    wr(ADDR_CFG, 8'h1c);
    rd(ADDR_IN_LO, d);
    rd(ADDR_IN_HI, d);
    wr(ADDR_P0_LO, 8'hff);
    settle(6);
    chk_irq("irq_outpin", 1'b0);
    @(posedge clk_sys);
    ext_low <= 16'h0008;
    settle(5);
    chk_irq("irq_set", 1'b1);
    @(posedge clk_sys);
    ext_low <= 16'h0000;
    settle(5);
    chk_irq("irq_auto", 1'b0);
    @(posedge clk_sys);
    ext_low <= 16'h0200;
    settle(5);
    rd(ADDR_IN_LO, d);
    settle(3);
    chk_irq("irq_other", 1'b1);
    rd(ADDR_IN_HI, d);
    settle(3);
    chk_irq("irq_read", 1'b0);
    wr(ADDR_CFG, 8'h0c);
    @(posedge clk_sys);
    ext_low <= 16'h0000;
    settle(5);
    chk_irq("irq_off", 1'b0);
    wr(ADDR_CFG, 8'h08);
    settle(4);
    chk_irq("o16_gpo", 1'b1);
  endtask

  task automatic t_blink;
    logic [7:0] d;
    wr(ADDR_DIR_LO, 8'h00);
    wr(ADDR_P0_LO, 8'h0f);
    wr(ADDR_P1_LO, 8'hf0);
    settle(3);
    chk("oe_static", 16'h00f0, port_pins_oe);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys);
      blink_in <= i[1];
      wr(ADDR_CFG, 8'h05 | {6'h00, i[0], 1'b0});
      settle(4);
      chk("oe_blink", (i[1] ^ i[0]) ? 16'h000f : 16'h00f0, port_pins_oe);
      chk_irq("o16_blink", i[1] ^ i[0]);
    end
    wr(ADDR_CFG, 8'h06);
    settle(3);
    chk("oe_noblink", 16'h00f0, port_pins_oe);
    rd(ADDR_CFG, d);
    chk("blink_stat", 16'h0086, {8'h00, d});
    @(posedge clk_sys);
    blink_in <= 1'b0;
    settle(4);
    rd(ADDR_CFG, d);
    chk("blink_gpi", 16'h0006, {8'h00, d});
  endtask

  // 30 ns dips must vanish, 100 ns dips must pass
  task automatic t_filter;
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk_sys);
      {scl_low, sda_low} <= k[0] ? 2'b01 : 2'b10;
      repeat (3) @(posedge clk_sys);
      {scl_low, sda_low} <= 2'b00;
      for (int j = 0; j < 8; j++)
      begin
        settle(1);
        chk("filt_spike", 16'h0003, {14'h0000, scl_filt, sda_filt});
      end
      @(posedge clk_sys);
      {scl_low, sda_low} <= k[0] ? 2'b01 : 2'b10;
      settle(10);
      chk("filt_long", k[0] ? 16'h0002 : 16'h0001, {14'h0000, scl_filt, sda_filt});
      @(posedge clk_sys);
      {scl_low, sda_low} <= 2'b00;
      settle(10);
    end
  endtask

  task automatic t_strap;
    for (int m = 0; m < 4; m++)
    begin
      do_reset(m[1:0]);
      @(posedge clk_sys);
      frame <= m[1];
      settle(400);
      frame <= 1'b0;
      settle(10);
      chk("strap", {9'h000, 7'h20 | {m[1], 3'h0, m[0], 2'h0}}, {9'h000, slave_addr});
    end
  endtask

  // ----------------------------------------
  // main
  // ----------------------------------------
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      finish_test();
    end
  end

  initial
  begin
    do_reset(2'h0);
    t_reset(7'h20);
    t_inputs();
    t_irq();
    t_blink();
    t_filter();
    do_reset(2'h1);
    t_reset(7'h24);
    t_strap();
    finish_test();
  end
endmodule
